// file: verilog/acd_pkg.sv
// Shared constants, opcodes and carrier types for the accumulator processor
package acd_pkg;

    localparam int WORD_W  = 16;
    localparam int ADDR_W  = 15;
    localparam int FIELD_W = 12;

    // Word fields; printed bit 0 is the most significant bit, index 15 here
    localparam int IND_BIT  = 15;
    localparam int OP_HI    = 14;
    localparam int OP_LO    = 12;
    localparam int FIELD_HI = 11;
    localparam int SUB_HI   = 11;
    localparam int SUB_LO   = 8;
    localparam int DEV_HI   = 7;
    localparam int DEV_LO   = 4;
    localparam int ARG_HI   = 3;
    localparam int ARG_LO   = 0;

    // Operation codes: memory reference ones, plus OP_GROUP for the group instructions
    localparam logic [2:0] OP_LOAD  = 3'h0;
    localparam logic [2:0] OP_JUMP  = 3'h1;
    localparam logic [2:0] OP_ADD   = 3'h2;
    localparam logic [2:0] OP_CALL  = 3'h3;
    localparam logic [2:0] OP_AND   = 3'h4;
    localparam logic [2:0] OP_STORE = 3'h5;
    localparam logic [2:0] OP_INDEX = 3'h6;
    localparam logic [2:0] OP_GROUP = 3'h7;

    // Group sub-codes: {word bit 15, word bits 11:8}
    localparam logic [4:0] SUB_SHIFT_LEFT  = 5'h00;
    localparam logic [4:0] SUB_ROTATE_LEFT = 5'h10;
    localparam logic [4:0] SUB_SKIP_ZERO   = 5'h04;
    localparam logic [4:0] SUB_SKIP_NZERO  = 5'h14;
    localparam logic [4:0] SUB_SKIP_BSET   = 5'h15;
    localparam logic [4:0] SUB_SKIP_BCLR   = 5'h05;
    localparam logic [4:0] SUB_SKIP_NOVF   = 5'h06;
    localparam logic [4:0] SUB_COMPLEMENT  = 5'h13;
    localparam logic [4:0] SUB_CLEAR       = 5'h03;
    localparam logic [4:0] SUB_SENSE_SKIP  = 5'h01;
    localparam logic [4:0] SUB_OUTPUT      = 5'h11;
    localparam logic [4:0] SUB_INPUT       = 5'h1C;
    localparam logic [4:0] SUB_HALT        = 5'h09;

    localparam logic [14:0] PC_RESET = 15'h0000;
    localparam logic [15:0] AC_RESET = 16'h0000;

    localparam int CLK_PERIOD_NS  = 8;
    localparam int IN_STROBE_NS   = 16;
    localparam int IN_STROBE_CYC  =
        (IN_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [14:0] addr;
        logic [15:0] wdata;
    } acd_mem_t;

    typedef struct packed {
        logic [3:0]  dev;
        logic [3:0]  func;
        logic [15:0] data;
    } acd_io_t;

endpackage : acd_pkg

// file: verilog/acd_core.sv
// Decode and execute core of the accumulator processor with its I/O bus
// Function
// RQ1: All words are 16 bits and arithmetic is two's complement.
// RQ2: Instruction bit 0 is indirect, next three opcode, last twelve address.
// RQ3: Indirect word gives a 15-bit address and its own indirect flag.
// RQ4: Data words carry a sign in bit 0 and fifteen data bits.
// RQ5: Clear, load, add and store accumulator instructions exist.
// RQ6: AND combines the memory word bitwise into the accumulator.
// RQ7: Complement replaces the accumulator with its two's complement.
// RQ8: Rotate left wraps top bits to bottom; shift left fills zeros.
// RQ9: Skip next instruction when accumulator is zero, or when non-zero.
// RQ10: Skip next instruction when a selected accumulator bit is one or zero.
// RQ11: Skip next instruction according to the overflow indicator.
// RQ12: Devices raise sense when ready; sense test skips when line true.
// RQ13: Input moves one 16-bit word from the device into the accumulator.
// RQ14: Output moves one 16-bit word from the accumulator to the device.
// RQ15: Device address field selects the peripheral; only it responds.
// RQ16: Jump loads the program counter with the effective address.
// RQ17: Call saves the return address in memory, allowing code in ROM.
// RQ18: Index increments the addressed memory word in place.
// RQ19: Call writes address plus one at operand, continues at operand+1, clears AC.
// RQ20: Index skips when the result is zero; AC receives the result.
// RQ21: Add sets overflow; it holds until next add, index or clear.
// RQ22: Output drives data, address, function with a one-cycle output strobe.
// RQ23: PC advances one per instruction, two when a skip is taken.
// RQ24: Device holds input data while the input strobe is active.
`timescale 1ns/1ps
`default_nettype none

module acd_core
    import acd_pkg::*;
#(
    parameter logic [14:0] START_ADDR     = PC_RESET,
    parameter int          IN_STROBE_CYCS = IN_STROBE_CYC
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [15:0] mem_rdata,
    input  wire logic        mem_ack,
    input  wire logic [15:0] sense_in,
    input  wire logic [15:0] io_din,
    input  wire logic        run_req,
    output var  acd_mem_t    mem_out,
    output var  acd_io_t     io_out,
    output var  logic        output_strobe,
    output var  logic        input_strobe,
    output var  logic        halted,
    output var  logic [15:0] acc_out,
    output var  logic        overflow_out
);

    if (IN_STROBE_CYCS < 1 || IN_STROBE_CYCS > 255) begin : g_chk
        $error("acd_core: IN_STROBE_CYCS must be 1 to 255");
    end

    typedef enum logic [3:0] {
        ST_FETCH,
        ST_FETCH_WAIT,
        ST_DECODE,
        ST_IND_WAIT,
        ST_EXEC,
        ST_OPER_WAIT,
        ST_WRITE_WAIT,
        ST_IN_STROBE,
        ST_HALT
    } acd_state_t;

    localparam logic [7:0] STROBE_LAST = 8'(IN_STROBE_CYCS - 1);

    function automatic logic [15:0] acd_rotl(input logic [15:0] v,
                                             input logic [3:0]  n);
        logic [31:0] dbl;
        dbl = {v, v} << n;
        return dbl[31:16];
    endfunction : acd_rotl

    function automatic logic [15:0] acd_inc(input logic [15:0] v);
        return 16'(v + 16'h0001);
    endfunction : acd_inc

    acd_state_t  state_ff,  nxt_state;
    logic [14:0] pc_ff,     nxt_pc;
    logic [15:0] ir_ff,     nxt_ir;
    logic [15:0] ac_ff,     nxt_ac;
    logic        ovf_ff,    nxt_ovf;
    logic [14:0] ea_ff,     nxt_ea;
    logic [7:0]  cnt_ff,    nxt_cnt;
    acd_mem_t    mem_ff,    nxt_mem;
    acd_io_t     io_ff,     nxt_io;
    logic        ostb_ff,   nxt_ostb;
    logic        istb_ff,   nxt_istb;
    logic        halt_ff,   nxt_halt;

    // Instruction decode [RQ2]
    wire logic        ir_ind  = ir_ff[IND_BIT];
    wire logic [2:0]  ir_op   = ir_ff[OP_HI:OP_LO];
    wire logic [11:0] ir_fld  = ir_ff[FIELD_HI:0];
    wire logic [4:0]  ir_sub  = {ir_ff[IND_BIT], ir_ff[SUB_HI:SUB_LO]};
    wire logic [3:0]  ir_dev  = ir_ff[DEV_HI:DEV_LO];
    wire logic [3:0]  ir_arg  = ir_ff[ARG_HI:ARG_LO];
    wire logic [14:0] fld_adr = {3'h0, ir_fld};

    // Indirect word: sign position is its flag, rest the address [RQ3]
    wire logic        rd_ind  = mem_rdata[IND_BIT];
    wire logic [14:0] rd_adr  = mem_rdata[14:0];

    // Two's complement datapath on full words [RQ1] [RQ4]
    wire logic [15:0] add_sum = 16'(ac_ff + mem_rdata);
    wire logic        add_ovf = (ac_ff[15] == mem_rdata[15]) &&
                                (add_sum[15] != ac_ff[15]);
    wire logic [15:0] inc_val = acd_inc(mem_rdata);
    wire logic [15:0] neg_ac  = 16'(~ac_ff + 16'h0001);
    wire logic        ac_zero = (ac_ff == 16'h0000);
    // Printed bit B counts from the most significant end
    wire logic        sel_bit = ac_ff[4'hF - ir_arg];
    wire logic [14:0] pc_skip = 15'(pc_ff + 15'h0001);
    wire logic [14:0] ea_next = 15'(ea_ff + 15'h0001);

    always_comb begin
        nxt_state = state_ff;
        nxt_pc    = pc_ff;
        nxt_ir    = ir_ff;
        nxt_ac    = ac_ff;
        nxt_ovf   = ovf_ff;
        nxt_ea    = ea_ff;
        nxt_cnt   = cnt_ff;
        nxt_mem   = mem_ff;
        nxt_io    = io_ff;
        nxt_ostb  = 1'b0;
        nxt_istb  = istb_ff;
        unique case (state_ff)
            ST_FETCH: begin
                nxt_mem.req  = 1'b1;
                nxt_mem.we   = 1'b0;
                nxt_mem.addr = pc_ff;
                nxt_state    = ST_FETCH_WAIT;
            end
            ST_FETCH_WAIT: begin
                if (mem_ack) begin
                    nxt_mem.req = 1'b0;
                    nxt_ir      = mem_rdata;
                    nxt_pc      = pc_skip; // [RQ23]
                    nxt_state   = ST_DECODE;
                end
            end
            ST_DECODE: begin
                if (ir_op != OP_GROUP) begin
                    if (ir_ind) begin
                        nxt_mem.req  = 1'b1;
                        nxt_mem.we   = 1'b0;
                        nxt_mem.addr = fld_adr;
                        nxt_state    = ST_IND_WAIT;
                    end else begin
                        nxt_ea    = fld_adr;
                        nxt_state = ST_EXEC;
                    end
                end else begin
                    nxt_state = ST_FETCH;
                    unique case (ir_sub)
                        SUB_CLEAR: begin
                            nxt_ac  = AC_RESET; // [RQ5]
                            nxt_ovf = 1'b0; // [RQ21]
                        end
                        SUB_COMPLEMENT: nxt_ac = neg_ac; // [RQ7]
                        SUB_ROTATE_LEFT: begin
                            nxt_ac = acd_rotl(ac_ff, ir_arg); // [RQ8]
                        end
                        SUB_SHIFT_LEFT: begin
                            nxt_ac = 16'(ac_ff << ir_arg); // [RQ8]
                        end
                        SUB_SKIP_ZERO: begin
                            if (ac_zero) nxt_pc = pc_skip; // [RQ9] [RQ23]
                        end
                        SUB_SKIP_NZERO: begin
                            if (!ac_zero) nxt_pc = pc_skip; // [RQ9]
                        end
                        SUB_SKIP_BSET: begin
                            if (sel_bit) nxt_pc = pc_skip; // [RQ10]
                        end
                        SUB_SKIP_BCLR: begin
                            if (!sel_bit) nxt_pc = pc_skip; // [RQ10]
                        end
                        SUB_SKIP_NOVF: begin
                            if (!ovf_ff) nxt_pc = pc_skip; // [RQ11]
                        end
                        SUB_SENSE_SKIP: begin
                            if (sense_in[ir_arg]) nxt_pc = pc_skip; // [RQ12]
                        end
                        SUB_OUTPUT: begin
                            // Data, address and function change on the
                            // same edge as the strobe rises [RQ22]
                            nxt_io.dev  = ir_dev; // [RQ15]
                            nxt_io.func = ir_arg;
                            nxt_io.data = ac_ff; // [RQ14]
                            nxt_ostb    = 1'b1; // [RQ22]
                        end
                        SUB_INPUT: begin
                            nxt_io.dev  = ir_dev; // [RQ15]
                            nxt_io.func = ir_arg;
                            nxt_istb    = 1'b1;
                            nxt_cnt     = STROBE_LAST;
                            nxt_state   = ST_IN_STROBE;
                        end
                        SUB_HALT: nxt_state = ST_HALT;
                        default: ; // Unassigned group codes act as no-ops
                    endcase
                end
            end
            ST_IND_WAIT: begin
                if (mem_ack) begin
                    if (rd_ind) begin
                        // Chains are followed as deep as memory says [RQ3]
                        nxt_mem.addr = rd_adr;
                    end else begin
                        nxt_mem.req = 1'b0;
                        nxt_ea      = rd_adr;
                        nxt_state   = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                unique case (ir_op)
                    OP_JUMP: begin
                        nxt_pc    = ea_ff; // [RQ16]
                        nxt_state = ST_FETCH;
                    end
                    OP_CALL: begin
                        // Link goes to the operand word, so code may be ROM
                        nxt_mem.req   = 1'b1; // [RQ17]
                        nxt_mem.we    = 1'b1;
                        nxt_mem.addr  = ea_ff;
                        nxt_mem.wdata = {1'b0, pc_ff}; // [RQ19]
                        nxt_pc        = ea_next; // [RQ19]
                        nxt_ac        = AC_RESET; // [RQ19]
                        nxt_state     = ST_WRITE_WAIT;
                    end
                    OP_STORE: begin
                        nxt_mem.req   = 1'b1;
                        nxt_mem.we    = 1'b1;
                        nxt_mem.addr  = ea_ff;
                        nxt_mem.wdata = ac_ff; // [RQ5]
                        nxt_state     = ST_WRITE_WAIT;
                    end
                    OP_GROUP: nxt_state = ST_FETCH;
                    default: begin
                        // Load, add, and, index all read the operand first
                        nxt_mem.req  = 1'b1;
                        nxt_mem.we   = 1'b0;
                        nxt_mem.addr = ea_ff;
                        nxt_state    = ST_OPER_WAIT;
                    end
                endcase
            end
            ST_OPER_WAIT: begin
                if (mem_ack) begin
                    nxt_mem.req = 1'b0;
                    nxt_state   = ST_FETCH;
                    unique case (ir_op)
                        OP_LOAD: nxt_ac = mem_rdata; // [RQ5]
                        OP_ADD: begin
                            nxt_ac  = add_sum; // [RQ5] [RQ1]
                            nxt_ovf = add_ovf; // [RQ21]
                        end
                        OP_AND: nxt_ac = ac_ff & mem_rdata; // [RQ6]
                        OP_INDEX: begin
                            nxt_ac        = inc_val; // [RQ20]
                            nxt_ovf       = (inc_val == 16'h0000); // [RQ21]
                            nxt_mem.req   = 1'b1; // [RQ18]
                            nxt_mem.we    = 1'b1;
                            nxt_mem.wdata = inc_val; // [RQ18]
                            nxt_state     = ST_WRITE_WAIT;
                            if (inc_val == 16'h0000) begin
                                nxt_pc = pc_skip; // [RQ20]
                            end
                        end
                        default: ;
                    endcase
                end
            end
            ST_WRITE_WAIT: begin
                if (mem_ack) begin
                    nxt_mem.req = 1'b0;
                    nxt_mem.we  = 1'b0;
                    nxt_state   = ST_FETCH;
                end
            end
            ST_IN_STROBE: begin
                // Device keeps its word on io_din while the strobe is high,
                // so the word is taken on the last strobe cycle [RQ24]
                if (cnt_ff == 8'h00) begin
                    nxt_ac    = io_din; // [RQ13]
                    nxt_istb  = 1'b0;
                    nxt_state = ST_FETCH;
                end else begin
                    nxt_cnt = 8'(cnt_ff - 8'h01);
                end
            end
            ST_HALT: begin
                if (run_req) nxt_state = ST_FETCH;
            end
            default: nxt_state = ST_FETCH;
        endcase
    end

    // Kept in its own flop so the halted port needs no decode after a flop
    assign nxt_halt = (nxt_state == ST_HALT);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= ST_FETCH;
            pc_ff    <= START_ADDR;
            ir_ff    <= 16'h0000;
            ac_ff    <= AC_RESET;
            ovf_ff   <= 1'b0;
            ea_ff    <= 15'h0000;
            cnt_ff   <= 8'h00;
            mem_ff   <= '0;
            io_ff    <= '0;
            ostb_ff  <= 1'b0;
            istb_ff  <= 1'b0;
            halt_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            pc_ff    <= nxt_pc;
            ir_ff    <= nxt_ir;
            ac_ff    <= nxt_ac;
            ovf_ff   <= nxt_ovf;
            ea_ff    <= nxt_ea;
            cnt_ff   <= nxt_cnt;
            mem_ff   <= nxt_mem;
            io_ff    <= nxt_io;
            ostb_ff  <= nxt_ostb;
            istb_ff  <= nxt_istb;
            halt_ff  <= nxt_halt;
        end
    end

    assign mem_out       = mem_ff;
    assign io_out        = io_ff;
    assign output_strobe = ostb_ff;
    assign input_strobe  = istb_ff;
    assign halted        = halt_ff;
    assign acc_out       = ac_ff;
    assign overflow_out  = ovf_ff;

endmodule : acd_core

`default_nettype wire

// file: sim/acd_core_asserts.sv
// Concurrent checks on the ports of the processor core
`timescale 1ns/1ps
`default_nettype none

module acd_core_asserts
    import acd_pkg::*;
#(
    parameter int IN_STROBE_CYCS = IN_STROBE_CYC
) (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [15:0] mem_rdata,
    input wire logic        mem_ack,
    input wire logic [15:0] sense_in,
    input wire logic [15:0] io_din,
    input wire logic        run_req,
    input wire acd_mem_t    mem_out,
    input wire acd_io_t     io_out,
    input wire logic        output_strobe,
    input wire logic        input_strobe,
    input wire logic        halted,
    input wire logic [15:0] acc_out,
    input wire logic        overflow_out
);
    logic [7:0] in_cnt_ff;

    // Length of the current input strobe, so long strobes need no repetition
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            in_cnt_ff <= 8'h00;
        end else begin
            in_cnt_ff <= input_strobe ? in_cnt_ff + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_out_pulse: assert property (
        output_strobe |=> !output_strobe
    ) else $error("output strobe longer than one cycle");
    a_out_data: assert property (
        output_strobe |-> io_out.data == acc_out
    ) else $error("output data differs from accumulator");
    a_in_length: assert property (
        $fell(input_strobe) |-> in_cnt_ff == IN_STROBE_CYCS
    ) else $error("input strobe has wrong length");
    a_in_capture: assert property (
        $fell(input_strobe) |-> acc_out == $past(io_din)
    ) else $error("input word not loaded into accumulator");
    a_in_select: assert property (
        input_strobe && $past(input_strobe) |-> $stable(io_out)
    ) else $error("device select moved during input");
    a_req_hold: assert property (
        mem_out.req && !mem_ack |=> mem_out.req && $stable(mem_out)
    ) else $error("memory request changed before answer");
    a_req_drop: assert property (
        $fell(mem_out.req) |-> $past(mem_ack)
    ) else $error("memory request dropped without answer");
    a_fetch_next: assert property (
        output_strobe |-> ##[1:3] (mem_out.req && !mem_out.we)
    ) else $error("no fetch after output");
    a_halt_quiet: assert property (
        halted |-> !output_strobe && !input_strobe && !mem_out.req
    ) else $error("activity while halted");
endmodule : acd_core_asserts

bind acd_core acd_core_asserts #(.IN_STROBE_CYCS(IN_STROBE_CYCS))
    u_acd_core_asserts (.clk(clk), .reset(reset), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .sense_in(sense_in), .io_din(io_din),
    .run_req(run_req), .mem_out(mem_out), .io_out(io_out),
    .output_strobe(output_strobe), .input_strobe(input_strobe),
    .halted(halted), .acc_out(acc_out), .overflow_out(overflow_out));

`default_nettype wire

// file: sim/acd_far_model.sv
// Behavioural memory and I/O devices facing the processor core
`timescale 1ns/1ps
`default_nettype none

module acd_far_model
    import acd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire acd_mem_t    mem_in,
    input  wire acd_io_t     io_in,
    input  wire logic        input_strobe,
    input  wire logic        output_strobe,
    input  wire logic [1:0]  dly,
    input  wire logic [15:0] dev_word,
    output var  logic [15:0] mem_rdata,
    output var  logic        mem_ack,
    output var  logic [15:0] sense_in,
    output var  logic [15:0] io_din
);
    logic [15:0] mem [0:4095];
    logic [1:0]  wait_ff;
    logic [15:0] tick_ff;
    logic [15:0] latch_ff;
    wire  logic  sel_in;

    assign sel_in = input_strobe && io_in.dev == 4'h2;
    // Only the input device reports ready; all others stay quiet
    assign sense_in = 16'h0004;
    // Unselected input lines churn so a stale capture cannot pass
    assign io_din = sel_in ? dev_word : tick_ff;

    // Answer delay follows dly, which the bench varies every cycle
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            mem_ack <= 1'b0;
            wait_ff <= 2'h0;
            tick_ff <= 16'hA5C3;
            mem_rdata <= 16'h5A5A;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            tick_ff <= tick_ff + 16'h1357;
            if (mem_in.req && !mem_ack) begin
                if (wait_ff >= dly) begin
                    mem_ack <= 1'b1;
                    wait_ff <= 2'h0;
                    if (mem_in.we) begin
                        mem[mem_in.addr[11:0]] <= mem_in.wdata;
                    end else begin
                        mem_rdata <= mem[mem_in.addr[11:0]];
                    end
                end else begin
                    wait_ff <= wait_ff + 2'h1;
                end
            end
        end
    end

    always @(posedge clk) begin
        if (output_strobe && io_in.dev == 4'h3) begin
            latch_ff <= io_in.data;
        end
    end
endmodule : acd_far_model

`default_nettype wire

// file: sim/test_acd_core.sv
// Self-checking bench for the accumulator processor core
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("[FAIL] %0t got %h expected %h", $time, got, exp); \
        end \
    end

module test_acd_core
    import acd_pkg::*;
;
    logic        clk, reset, run_req;
    logic [1:0]  dly;
    logic [15:0] dev_word, a, b, c, s, r, rt, ev;
    wire  logic [15:0] mem_rdata, sense_in, io_din, acc_out;
    wire  logic  mem_ack, output_strobe, input_strobe, halted, overflow_out;
    acd_mem_t    mem_out;
    acd_io_t     io_out;
    int          seed = 96634;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          pa;
    logic [15:0] exq [$];

    acd_core u_acd_core (.clk(clk), .reset(reset), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack), .sense_in(sense_in), .io_din(io_din),
        .run_req(run_req), .mem_out(mem_out), .io_out(io_out),
        .output_strobe(output_strobe), .input_strobe(input_strobe),
        .halted(halted), .acc_out(acc_out), .overflow_out(overflow_out));
    acd_far_model u_acd_far_model (.clk(clk), .reset(reset),
        .mem_in(mem_out), .io_in(io_out), .input_strobe(input_strobe),
        .output_strobe(output_strobe), .dly(dly), .dev_word(dev_word),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .sense_in(sense_in),
        .io_din(io_din));

    function automatic logic [15:0] mr(input logic [2:0] op,
                                       input logic [11:0] ad);
        return {1'b0, op, ad};
    endfunction : mr
    function automatic logic [15:0] gr(input logic [4:0] sc,
                                       input logic [7:0] lo);
        return {sc[4], OP_GROUP, sc[3:0], lo};
    endfunction : gr
    task automatic poke(input logic [11:0] ad, input logic [15:0] w);
        u_acd_far_model.mem[ad] = w;
    endtask : poke
    task automatic put(input logic [15:0] w);
        poke(12'(pa), w);
        pa++;
    endtask : put
    // Output to device 3, function 5, with its expected word queued
    task automatic dot(input logic [15:0] v);
        put(gr(SUB_OUTPUT, 8'h35));
        exq.push_back(v);
    endtask : dot
    // A slot that must be skipped; executing it leaves an unqueued output
    task automatic bad();
        put(gr(SUB_OUTPUT, 8'hEE));
    endtask : bad
    task automatic wait_halt(input logic lvl);
        int n;
        n = 0;
        while (halted !== lvl && n < 5000) begin
            @(negedge clk);
            n++;
        end
        `CHK(halted, lvl)
    endtask : wait_halt
    // One-cycle run request, then wait until the core has left halt
    task automatic resume();
        @(posedge clk);
        run_req <= 1'b1;
        @(posedge clk);
        run_req <= 1'b0;
        wait_halt(1'b0);
    endtask : resume
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        dly <= 2'($random(seed));
    end

    always @(negedge clk) begin
        if (reset === 1'b0 && output_strobe === 1'b1) begin
            if (exq.size() == 0) begin
                n_mismatch++;
                $display("[FAIL] %0t output with nothing expected", $time);
            end else begin
                ev = exq.pop_front();
                `CHK(io_out.data, ev)
                `CHK(io_out.dev, 4'h3)
                `CHK(io_out.func, 4'h5)
            end
        end
    end

    initial begin
        #200000;
        n_mismatch++;
        final_report();
    end

    initial begin
        reset = 1'b1;
        run_req = 1'b0;
        a = 16'($random(seed));
        b = 16'($random(seed));
        c = 16'($random(seed));
        dev_word = 16'($random(seed));
        s = (a + b) & c;
        r = ~s + 16'h0001;
        poke(12'h100, a);
        poke(12'h101, b);
        poke(12'h102, c);
        poke(12'h104, 16'h0103);
        poke(12'h105, 16'h8001);
        poke(12'h106, 16'h7FFF);
        poke(12'h107, 16'h0001);
        poke(12'h108, 16'hFFFF);
        poke(12'h109, 16'h0041);
        poke(12'h10A, 16'h8104);
        pa = 0;
        put(mr(OP_LOAD, 12'h100));
        dot(a);
        put(mr(OP_ADD, 12'h101));
        dot(a + b);
        put(mr(OP_AND, 12'h102));
        dot(s);
        put(mr(OP_STORE, 12'h103));
        put(gr(SUB_CLEAR, 8'h00));
        put({1'b1, OP_LOAD, 12'h10A});
        dot(s);
        put(gr(SUB_COMPLEMENT, 8'h00));
        dot(r);
        put(gr(SUB_ROTATE_LEFT, 8'h03));
        dot({r[12:0], r[15:13]});
        put(gr(SUB_SHIFT_LEFT, 8'h04));
        dot({r[8:0], r[15:13], 4'h0});
        put(gr(SUB_CLEAR, 8'h00));
        put(gr(SUB_SKIP_ZERO, 8'h00));
        bad();
        put(mr(OP_LOAD, 12'h105));
        put(gr(SUB_SKIP_BSET, 8'h00));
        bad();
        put(gr(SUB_SKIP_NZERO, 8'h00));
        bad();
        put(gr(SUB_SKIP_BCLR, 8'h01));
        bad();
        put(gr(SUB_SKIP_ZERO, 8'h00));
        dot(16'h8001);
        put(mr(OP_LOAD, 12'h106));
        put(mr(OP_ADD, 12'h107));
        put(gr(SUB_SKIP_NOVF, 8'h00));
        dot(16'h8000);
        put(gr(SUB_HALT, 8'h00));
        put(gr(SUB_CLEAR, 8'h00));
        put(gr(SUB_SKIP_NOVF, 8'h00));
        bad();
        put(mr(OP_INDEX, 12'h108));
        bad();
        put(mr(OP_INDEX, 12'h109));
        dot(16'h0042);
        put(mr(OP_LOAD, 12'h108));
        dot(16'h0000);
        put(gr(SUB_INPUT, 8'h21));
        dot(dev_word);
        put(gr(SUB_SENSE_SKIP, 8'h02));
        bad();
        put(gr(SUB_SENSE_SKIP, 8'h09));
        dot(dev_word);
        rt = 16'(pa + 1);
        put(mr(OP_CALL, 12'h110));
        pa = 'h111;
        dot(16'h0000);
        put(mr(OP_LOAD, 12'h110));
        dot(rt);
        put(mr(OP_JUMP, 12'h0C0));
        pa = 'h0C0;
        put(gr(SUB_HALT, 8'h00));
        dot(rt);
        put(gr(SUB_HALT, 8'h00));
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        `CHK(acc_out, AC_RESET)
        wait_halt(1'b1);
        `CHK(overflow_out, 1'b1)
        resume();
        wait_halt(1'b1);
        resume();
        wait_halt(1'b1);
        `CHK(overflow_out, 1'b0)
        repeat (4) @(negedge clk);
        `CHK(u_acd_far_model.latch_ff, rt)
        `CHK(u_acd_far_model.mem[12'h103], s)
        `CHK(u_acd_far_model.mem[12'h110], rt)
        `CHK(u_acd_far_model.mem[12'h108], 16'h0000)
        `CHK(u_acd_far_model.mem[12'h109], 16'h0042)
        `CHK(exq.size(), 0)
        final_report();
    end
endmodule : test_acd_core

`default_nettype wire
